// [acpp_regs.vh]
`ifndef ACPP_REGS_VH
`define ACPP_REGS_VH

// ----------------------------------------------------------------------------
// Host I/O addresses
// ----------------------------------------------------------------------------
`define ACPP_IO_ATTR_INDEX 16'h03C0
`define ACPP_IO_ATTR_DATA 16'h03C1
`define ACPP_IO_STAT_MONO 16'h03BA
`define ACPP_IO_STAT_COLOR 16'h03DA
`define ACPP_IO_PIX_MASK 16'h03C6
`define ACPP_IO_PAL_RD_INDEX 16'h03C7
`define ACPP_IO_PAL_WR_INDEX 16'h03C8
`define ACPP_IO_PAL_DATA 16'h03C9

// ----------------------------------------------------------------------------
// Attribute controller internal indexes
// ----------------------------------------------------------------------------
`define ACPP_IDX_PAL_LAST 5'h0F
`define ACPP_IDX_MODE 5'h10
`define ACPP_IDX_BORDER 5'h11
`define ACPP_IDX_PLANE_EN 5'h12
`define ACPP_IDX_PAN 5'h13
`define ACPP_IDX_PAD 5'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACPP_INDEX_VIDEO_EN 5
`define ACPP_MODE_GRAPHICS 0
`define ACPP_MODE_MONO 1
`define ACPP_MODE_LINE_GFX 2
`define ACPP_MODE_BLINK 3
`define ACPP_MODE_SPLIT_PAN 5
`define ACPP_MODE_ASM256 6
`define ACPP_MODE_PAD54 7

// ----------------------------------------------------------------------------
// Port mode selection and palette state codes
// ----------------------------------------------------------------------------
`define ACPP_PORTS_COMPAT 2'h0
`define ACPP_PORTS_SPLIT 2'h1
`define ACPP_PORTS_EITHER 2'h2
`define ACPP_PAL_STATE_WR 2'h0
`define ACPP_PAL_STATE_RD 2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ACPP_RST_INDEX 6'h00
`define ACPP_RST_MODE 8'h00
`define ACPP_RST_BORDER 8'h00
`define ACPP_RST_PLANE_EN 6'h0F
`define ACPP_RST_PAN 4'h0
`define ACPP_RST_PAD 4'h0
`define ACPP_RST_PAL_ENTRY 6'h00

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define ACPP_BLINK_BITS 5
`define ACPP_PAN_DEPTH 9
`define ACPP_LINE_GFX_LO 8'hC0
`define ACPP_LINE_GFX_HI 8'hDF

`endif

// [acpp_buf2.v]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-entry buffer
// ----------------------------------------------------------------------------
// A full two-entry queue: in_ready depends only on occupancy, so a stalled
// receiver never loses a word and the source sees back-pressure only once both entries fill.
module acpp_buf2 #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_q [0:1];
    reg rd_ptr_q;
    reg wr_ptr_q;
    reg [1:0] count_q;
    wire push;
    wire pop;

    assign in_ready = (count_q != 2'd2);
    assign out_valid = (count_q != 2'd0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_q[0] <= {W{1'b0}};
            mem_q[1] <= {W{1'b0}};
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q <= 2'd0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'd1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'd1;
            end
        end
    end
endmodule // acpp_buf2

`default_nettype wire

// [acpp_top.v]
// Summary of operation
// - In compatible mode index and data share one write port via a toggle.
// - A status-port read forces the toggle back to the index state.
// - Every write to the shared port flips the toggle.
// - Other reads leave the toggle alone; index reads at first port, data at second.
// - Split ports put data at the adjacent port so word writes load both.
// - The other extended setting accepts reads and writes at either port.
// - Index bits 4-0 select a register; bit 5 enables video, locks palette.
// - Sixteen palette entries hold 6-bit colors; upper bits read zero.
// - Mode bit 0 picks text or graphics, bit 1 color or mono.
// - Line-graphics codes copy pixel eight into pixel nine when bit 2 set.
// - Blink counter steps per vsync; bit 3 picks blink or intensity.
// - Mode bit 5 set stops panning in the lower split region.
// - Mode bit 6 set packs two 4-bit pixels into one byte.
// - Mode bit 7 takes video bits 5-4 from pad bits 1-0 except in 256-color mode.
// - Border color is output in the overscan intervals around display.
// - Cleared plane enable bits force the plane pixel bit to zero.
// - Status select routes two palette output bits to disp_status.
// - Panning shifts left; 9-dot, 8-dot and 256-color maps differ.
// - Pad bits 3-2 drive video bits 7-6 except in 256-color mode.
// - Pixel mask reads and writes pulse the palette strobes.
// - A 2-bit field records which palette index port was last written.
// - That field reads 00 after write-index, 11 after read-index port.
// - Palette state reads are answered here without a read strobe.
`timescale 1ns/100ps
`default_nettype none
`include "acpp_regs.vh"

module acpp_top #(
    parameter BLINK_BITS = `ACPP_BLINK_BITS
) (
    input wire clk,
    input wire rst,
    input wire [15:0] io_addr,
    input wire io_rd,
    input wire io_wr,
    input wire io_word,
    input wire [15:0] io_wdata,
    output reg [7:0] io_rdata,
    output reg io_rvalid,
    input wire [1:0] port_mode,
    output reg palette_read_strobe_n,
    output reg palette_write_strobe_n,
    output reg [7:0] pal_wdata,
    output reg pal_sel_mask,
    input wire [7:0] pal_rdata,
    output reg [1:0] disp_status,
    input wire pix_valid,
    output wire pix_ready,
    input wire [3:0] pix_planes,
    input wire [7:0] pix_attr,
    input wire [7:0] pix_char,
    input wire pix_font,
    input wire pix_ninth,
    input wire dot9_mode,
    input wire display_en,
    input wire blank,
    input wire lower_region,
    input wire vsync,
    output wire vid_valid,
    input wire vid_ready,
    output wire [7:0] vid_data
);
    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg [5:0] index_q;
    reg data_sel_q;
    reg [7:0] mode_q;
    reg [7:0] border_q;
    reg [5:0] plane_en_q;
    reg [3:0] pan_q;
    reg [3:0] pad_q;
    reg [5:0] pal_q [0:15];
    reg [1:0] pal_state_q;
    reg rd_pend_q;
    reg rd_ext_q;
    reg [7:0] rd_int_q;
    integer i;
    integer j;

    // ------------------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------------------
    wire at_index = (io_addr == `ACPP_IO_ATTR_INDEX);
    wire at_data = (io_addr == `ACPP_IO_ATTR_DATA);
    wire at_status = (io_addr == `ACPP_IO_STAT_MONO) || (io_addr == `ACPP_IO_STAT_COLOR);
    wire at_mask = (io_addr == `ACPP_IO_PIX_MASK);
    wire at_rd_idx = (io_addr == `ACPP_IO_PAL_RD_INDEX);
    wire at_wr_idx = (io_addr == `ACPP_IO_PAL_WR_INDEX);
    wire at_pdata = (io_addr == `ACPP_IO_PAL_DATA);
    wire mode_split = (port_mode == `ACPP_PORTS_SPLIT);
    wire mode_either = (port_mode == `ACPP_PORTS_EITHER);
    wire pal_locked = index_q[`ACPP_INDEX_VIDEO_EN];

    reg wr_index;
    reg wr_data;
    reg [7:0] wr_index_val;
    reg [7:0] wr_data_val;
    reg [4:0] wr_sel;
    reg toggle_flip;

    always @* begin
        wr_index = 1'b0;
        wr_data = 1'b0;
        toggle_flip = 1'b0;
        wr_index_val = io_wdata[7:0];
        wr_data_val = io_wdata[7:0];
        wr_sel = index_q[4:0];
        if (io_wr) begin
            if (mode_split) begin
                if (at_index) begin
                    wr_index = 1'b1;
                    if (io_word) begin
                        wr_data = 1'b1;
                        wr_data_val = io_wdata[15:8];
                        wr_sel = io_wdata[4:0];
                    end
                end else if (at_data) begin
                    wr_data = 1'b1;
                end
            end else if (at_index || (mode_either && at_data)) begin
                toggle_flip = 1'b1;
                wr_index = !data_sel_q;
                wr_data = data_sel_q;
            end
        end
    end

    // Data read mux for the attribute controller.
    reg [7:0] attr_data_rd;
    always @* begin
        attr_data_rd = 8'h00;
        if (index_q[4:0] <= `ACPP_IDX_PAL_LAST) begin
            attr_data_rd = pal_locked ? 8'h00 : {2'b00, pal_q[index_q[3:0]]};
        end else begin
            case (index_q[4:0])
                `ACPP_IDX_MODE: attr_data_rd = mode_q;
                `ACPP_IDX_BORDER: attr_data_rd = border_q;
                `ACPP_IDX_PLANE_EN: attr_data_rd = {2'b00, plane_en_q};
                `ACPP_IDX_PAN: attr_data_rd = {4'h0, pan_q};
                `ACPP_IDX_PAD: attr_data_rd = {4'h0, pad_q};
                default: attr_data_rd = 8'h00;
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            index_q <= `ACPP_RST_INDEX;
            data_sel_q <= 1'b0;
            mode_q <= `ACPP_RST_MODE;
            border_q <= `ACPP_RST_BORDER;
            plane_en_q <= `ACPP_RST_PLANE_EN;
            pan_q <= `ACPP_RST_PAN;
            pad_q <= `ACPP_RST_PAD;
            for (i = 0; i < 16; i = i + 1) begin
                pal_q[i] <= `ACPP_RST_PAL_ENTRY;
            end
            pal_state_q <= `ACPP_PAL_STATE_WR;
        end else begin
            if (io_rd && at_status) begin
                data_sel_q <= 1'b0;
            end else if (toggle_flip) begin
                data_sel_q <= ~data_sel_q;
            end
            if (wr_index) begin
                index_q <= wr_index_val[5:0];
            end
            if (wr_data) begin
                if (wr_sel <= `ACPP_IDX_PAL_LAST) begin
                    // Word writes check the lock from the index byte they carry.
                    if (!(wr_index ? wr_index_val[`ACPP_INDEX_VIDEO_EN] : pal_locked)) begin
                        pal_q[wr_sel[3:0]] <= wr_data_val[5:0];
                    end
                end else begin
                    case (wr_sel)
                        `ACPP_IDX_MODE: mode_q <= wr_data_val & 8'hEF;
                        `ACPP_IDX_BORDER: border_q <= wr_data_val;
                        `ACPP_IDX_PLANE_EN: plane_en_q <= wr_data_val[5:0];
                        `ACPP_IDX_PAN: pan_q <= wr_data_val[3:0];
                        `ACPP_IDX_PAD: pad_q <= wr_data_val[3:0];
                        default: pan_q <= pan_q;
                    endcase
                end
            end
            if (io_wr && at_wr_idx) begin
                pal_state_q <= `ACPP_PAL_STATE_WR;
            end else if (io_wr && at_rd_idx) begin
                pal_state_q <= `ACPP_PAL_STATE_RD;
            end
        end
    end

    // ------------------------------------------------------------------------
    // External palette strobes and read answer
    // ------------------------------------------------------------------------
    // External reads land one cycle after the strobe, so every read answers
    // two cycles after its request to keep a single fixed latency.
    wire ext_rd = io_rd && (at_mask || at_wr_idx || at_pdata);
    wire ext_wr = io_wr && (at_mask || at_rd_idx || at_wr_idx || at_pdata);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            palette_read_strobe_n <= 1'b1;
            palette_write_strobe_n <= 1'b1;
            pal_wdata <= 8'h00;
            pal_sel_mask <= 1'b0;
            rd_pend_q <= 1'b0;
            rd_ext_q <= 1'b0;
            rd_int_q <= 8'h00;
            io_rdata <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            palette_read_strobe_n <= !ext_rd;
            palette_write_strobe_n <= !ext_wr;
            if (ext_wr) begin
                pal_wdata <= io_wdata[7:0];
            end
            if (ext_rd || ext_wr) begin
                pal_sel_mask <= at_mask;
            end
            rd_pend_q <= io_rd;
            rd_ext_q <= ext_rd;
            if (io_rd) begin
                if (at_index && !(mode_either && data_sel_q)) begin
                    rd_int_q <= {2'b00, index_q};
                end else if (at_data || (mode_either && at_index)) begin
                    rd_int_q <= attr_data_rd;
                end else if (at_rd_idx) begin
                    rd_int_q <= {6'h00, pal_state_q};
                end else begin
                    rd_int_q <= 8'h00;
                end
            end
            io_rvalid <= rd_pend_q;
            if (rd_pend_q) begin
                io_rdata <= rd_ext_q ? pal_rdata : rd_int_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Blink counter
    // ------------------------------------------------------------------------
    reg vsync_q;
    reg [BLINK_BITS-1:0] blink_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            vsync_q <= 1'b0;
            blink_q <= {BLINK_BITS{1'b0}};
        end else begin
            vsync_q <= vsync;
            if (vsync && !vsync_q) begin
                blink_q <= blink_q + 1'b1;
            end
        end
    end
    wire blink_phase = blink_q[BLINK_BITS-1];

    // ------------------------------------------------------------------------
    // Pixel attribute path
    // ------------------------------------------------------------------------
    wire graphics = mode_q[`ACPP_MODE_GRAPHICS];
    wire mono = mode_q[`ACPP_MODE_MONO];
    wire blink_en = mode_q[`ACPP_MODE_BLINK];
    wire asm256 = mode_q[`ACPP_MODE_ASM256];
    reg half_q;
    reg [3:0] hi_nib_q;
    reg font_prev_q;
    reg [3:0] hist_q [0:`ACPP_PAN_DEPTH-1];
    wire buf_in_ready;
    wire push_now = !asm256 || half_q;
    wire accept = pix_valid && pix_ready;

    assign pix_ready = buf_in_ready || !push_now;

    reg font_bit;
    reg [3:0] fg_idx;
    reg [3:0] bg_idx;
    reg [3:0] new_idx;
    always @* begin
        font_bit = pix_font;
        if (pix_ninth) begin
            font_bit = 1'b0;
            if (mode_q[`ACPP_MODE_LINE_GFX] && pix_char >= `ACPP_LINE_GFX_LO && pix_char <= `ACPP_LINE_GFX_HI) begin
                font_bit = font_prev_q;
            end
        end
        fg_idx = pix_attr[3:0];
        bg_idx = blink_en ? {1'b0, pix_attr[6:4]} : pix_attr[7:4];
        if (mono) begin
            // Mono attributes only carry on/off and intensity.
            fg_idx = {pix_attr[3], 3'b111};
            bg_idx = blink_en ? 4'h0 : {pix_attr[7], 3'b000};
        end
        if (blink_en && pix_attr[7] && blink_phase) begin
            fg_idx = bg_idx;
        end
        if (graphics) begin
            new_idx = pix_planes;
            if (blink_en && blink_phase) begin
                new_idx[3] = 1'b0;
            end
        end else begin
            new_idx = font_bit ? fg_idx : bg_idx;
        end
        new_idx = new_idx & plane_en_q[3:0];
    end

    // ------------------------------------------------------------------------
    // Panning delay line
    // ------------------------------------------------------------------------
    // Unpanned output sits the full depth behind the input; panning taps a
    // younger entry, which shows pixels further right, i.e. shifts left.
    reg [3:0] shift;
    always @* begin
        if (asm256) begin
            shift = {2'b00, pan_q[2:1]};
        end else if (dot9_mode && !graphics) begin
            shift = (pan_q[3]) ? 4'd0 : pan_q + 4'd1;
        end else begin
            shift = {1'b0, pan_q[2:0]};
        end
        if (mode_q[`ACPP_MODE_SPLIT_PAN] && lower_region) begin
            shift = 4'd0;
        end
    end
    wire [3:0] tap_idx = hist_q[4'd8 - shift];
    wire [5:0] pal_out = pal_q[tap_idx];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (j = 0; j < `ACPP_PAN_DEPTH; j = j + 1) begin
                hist_q[j] <= 4'h0;
            end
            font_prev_q <= 1'b0;
            half_q <= 1'b0;
            hi_nib_q <= 4'h0;
        end else if (accept) begin
            hist_q[0] <= new_idx;
            for (j = 1; j < `ACPP_PAN_DEPTH; j = j + 1) begin
                hist_q[j] <= hist_q[j-1];
            end
            font_prev_q <= pix_font;
            half_q <= asm256 ? ~half_q : 1'b0;
            hi_nib_q <= pal_out[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // Palette and output byte assembly
    // ------------------------------------------------------------------------
    reg [7:0] vbyte;
    always @* begin
        if (asm256) begin
            vbyte = {hi_nib_q, pal_out[3:0]};
        end else begin
            vbyte[3:0] = pal_out[3:0];
            vbyte[5:4] = mode_q[`ACPP_MODE_PAD54] ? pad_q[1:0] : pal_out[5:4];
            vbyte[7:6] = pad_q[3:2];
        end
        if (!display_en) begin
            vbyte = blank ? 8'h00 : border_q;
        end
        if (!pal_locked) begin
            vbyte = 8'h00;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            disp_status <= 2'b00;
        end else if (accept && push_now) begin
            case (plane_en_q[5:4])
                2'b00: disp_status <= {vbyte[2], vbyte[0]};
                2'b01: disp_status <= {vbyte[5], vbyte[4]};
                2'b10: disp_status <= {vbyte[3], vbyte[1]};
                default: disp_status <= {vbyte[7], vbyte[6]};
            endcase
        end
    end

    acpp_buf2 #(
        .W(8)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(pix_valid && push_now),
        .in_ready(buf_in_ready),
        .in_data(vbyte),
        .out_valid(vid_valid),
        .out_ready(vid_ready),
        .out_data(vid_data)
    );
endmodule // acpp_top

`default_nettype wire

// [acpp_pal_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------
// External palette
// ----------------
module acpp_pal_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic sel_mask,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic stall,
    output logic ready,
    input wire logic [7:0] vid,
    output logic [7:0] pal_addr
);
    logic [7:0] mask_q;
    logic [7:0] reg_q;
    logic [7:0] last_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= 8'hff;
            reg_q <= 8'h00;
            last_q <= 8'h00;
        end else begin
            if (!wr_n && sel_mask) mask_q <= wdata;
            if (!wr_n && !sel_mask) reg_q <= wdata;
            if (!rd_n) last_q <= rdata;
        end
    end
    // A released bus shows the inverse of its last value, so stale data never looks right.
    assign rdata = !rd_n ? (sel_mask ? mask_q : reg_q) : ~last_q;
    assign ready = !stall;
    assign pal_addr = vid & mask_q;
endmodule // acpp_pal_model
`default_nettype wire

// [acpp_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------
// Port checks
// ----------------
module acpp_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic palette_read_strobe_n,
    input wire logic palette_write_strobe_n,
    input wire logic pal_sel_mask,
    input wire logic [7:0] pal_rdata,
    input wire logic vid_valid,
    input wire logic vid_ready,
    input wire logic [7:0] vid_data
);
    logic [1:0] state_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= 2'h0;
        end else if (io_wr && io_addr == 16'h03c7) begin
            state_q <= 2'h3;
        end else if (io_wr && io_addr == 16'h03c8) begin
            state_q <= 2'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_answer; io_rd |-> ##2 io_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_no_stray; io_rvalid |-> $past(io_rd, 2); endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray read answer");
    property p_mask_rd; io_rd && io_addr == 16'h03c6 |=> !palette_read_strobe_n && pal_sel_mask; endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask read strobe missing");
    property p_mask_wr; io_wr && io_addr == 16'h03c6 |=> !palette_write_strobe_n && pal_sel_mask; endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write strobe missing");
    property p_mask_data; io_rd && io_addr == 16'h03c6 ##1 1'b1 |=> io_rdata == $past(pal_rdata); endproperty
    a_mask_data: assert property (p_mask_data) else $error("mask read data wrong");
    property p_state_quiet; io_rd && io_addr == 16'h03c7 |=> palette_read_strobe_n; endproperty
    a_state_quiet: assert property (p_state_quiet) else $error("state read strobed");
    property p_state_data; io_rd && io_addr == 16'h03c7 |-> ##2 io_rdata == {6'h00, $past(state_q, 2)}; endproperty
    a_state_data: assert property (p_state_data) else $error("state read wrong");
    property p_rd_cause; !palette_read_strobe_n |-> $past(io_rd) && $past(io_addr) != 16'h03c7; endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read strobe without cause");
    property p_vid_hold; vid_valid && !vid_ready |=> vid_valid && $stable(vid_data); endproperty
    a_vid_hold: assert property (p_vid_hold) else $error("stalled video byte changed");
    c_mask: cover property (io_rd && io_addr == 16'h03c6);
    c_state: cover property (io_rd && io_addr == 16'h03c7 && state_q == 2'h3);
    c_stall: cover property (vid_valid && !vid_ready);
endmodule // acpp_props
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "acpp_regs.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
    logic clk, rst, io_rd, io_wr, io_word, io_rvalid, pix_valid, pix_ready, pix_font, pix_ninth;
    logic dot9_mode, display_en, blank, lower_region, vsync, vid_valid, vid_ready, stall, r;
    logic palette_read_strobe_n, palette_write_strobe_n, pal_sel_mask;
    logic [15:0] io_addr, io_wdata;
    logic [7:0] io_rdata, pal_wdata, pal_rdata, pix_attr, pix_char, vid_data, b, er, ev;
    logic [1:0] port_mode, disp_status;
    logic [3:0] pix_planes;
    logic [7:0] rd_q[$], vid_q[$];
    int num_errors = 0, samples_checked = 0, i;
    integer seed = 32'h0000_f266;
    acpp_top u_dut (.clk, .rst, .io_addr, .io_rd, .io_wr, .io_word, .io_wdata, .io_rdata, .io_rvalid,
        .port_mode, .palette_read_strobe_n, .palette_write_strobe_n, .pal_wdata, .pal_sel_mask,
        .pal_rdata, .disp_status, .pix_valid, .pix_ready, .pix_planes, .pix_attr, .pix_char,
        .pix_font, .pix_ninth, .dot9_mode, .display_en, .blank, .lower_region, .vsync, .vid_valid,
        .vid_ready, .vid_data);
    acpp_pal_model u_pal (.clk, .rst, .rd_n(palette_read_strobe_n), .wr_n(palette_write_strobe_n),
        .sel_mask(pal_sel_mask), .wdata(pal_wdata), .rdata(pal_rdata), .stall, .ready(vid_ready),
        .vid(vid_data), .pal_addr());
    // ----------------
    // Bus and pixel drivers
    // ----------------
    task automatic op(input int k, input logic [15:0] a, input logic [15:0] d, input logic [7:0] e);
        io_rd <= (k == 2);
        io_wr <= (k == 1 || k == 3);
        io_word <= (k == 3);
        io_addr <= a;
        io_wdata <= d;
        pix_valid <= 1'b0;
        if (k == 2) rd_q.push_back(e);
        @(posedge clk);
    endtask
    // Acceptance is judged at the falling edge, where the combinational ready has settled.
    task automatic px(input logic [7:0] e, input logic bl);
        pix_valid <= 1'b1;
        io_wr <= 1'b0;
        pix_planes <= 4'($random(seed));
        pix_attr <= 8'($random(seed));
        pix_char <= 8'($random(seed));
        blank <= bl;
        vid_q.push_back(e);
        do begin
            @(negedge clk);
            r = pix_ready;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask
    task automatic complete_run();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------
    // Result monitor
    // ----------------
    always @(posedge clk) begin
        if (io_rvalid === 1'b1) begin
            er = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx;
            `CHK("io_rdata", er, io_rdata)
        end
        if (vid_valid === 1'b1 && vid_ready === 1'b1) begin
            ev = (vid_q.size() > 0) ? vid_q.pop_front() : 8'hxx;
            `CHK("vid_data", ev, vid_data)
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    initial begin
        {io_rd, io_wr, io_word, pix_valid, stall, display_en, blank, lower_region, dot9_mode, vsync} = '0;
        {io_addr, io_wdata, port_mode, pix_planes, pix_attr, pix_char, pix_font, pix_ninth} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        op(1, `ACPP_IO_ATTR_INDEX, 16'h0010, 0);
        op(1, `ACPP_IO_ATTR_INDEX, 16'h0018, 0);
        op(2, `ACPP_IO_ATTR_DATA, 0, 8'h08);
        op(2, `ACPP_IO_ATTR_INDEX, 0, 8'h10);
        op(1, `ACPP_IO_ATTR_INDEX, 16'h0003, 0);
        op(1, `ACPP_IO_ATTR_INDEX, 16'h00ff, 0);
        op(2, `ACPP_IO_ATTR_DATA, 0, 8'h3f);
        op(1, `ACPP_IO_ATTR_INDEX, 16'h0012, 0);
        op(2, `ACPP_IO_STAT_COLOR, 0, 8'h00);
        op(1, `ACPP_IO_ATTR_INDEX, 16'h0023, 0);
        op(2, `ACPP_IO_ATTR_INDEX, 0, 8'h23);
        op(1, `ACPP_IO_ATTR_INDEX, 16'h003f, 0);
        op(2, `ACPP_IO_ATTR_DATA, 0, 8'h00);
        port_mode <= `ACPP_PORTS_SPLIT;
        op(3, `ACPP_IO_ATTR_INDEX, 16'h0c14, 0);
        op(2, `ACPP_IO_ATTR_DATA, 0, 8'h0c);
        op(2, `ACPP_IO_ATTR_INDEX, 0, 8'h14);
        port_mode <= `ACPP_PORTS_EITHER;
        op(2, `ACPP_IO_STAT_MONO, 0, 8'h00);
        op(1, `ACPP_IO_ATTR_DATA, 16'h0013, 0);
        op(1, `ACPP_IO_ATTR_DATA, 16'h0007, 0);
        op(2, `ACPP_IO_ATTR_DATA, 0, 8'h07);
        port_mode <= `ACPP_PORTS_COMPAT;
        b = 8'($random(seed));
        op(1, `ACPP_IO_PIX_MASK, {8'h00, b}, 0);
        op(2, `ACPP_IO_PIX_MASK, 0, b);
        for (i = 0; i < 2; i++) begin
            op(1, i ? `ACPP_IO_PAL_WR_INDEX : `ACPP_IO_PAL_RD_INDEX, 16'h0005, 0);
            op(2, `ACPP_IO_PAL_RD_INDEX, 0, i ? 8'h00 : 8'h03);
        end
        op(2, 16'h03d0, 0, 8'h00);
        stall <= 1'b1;
        op(2, `ACPP_IO_STAT_COLOR, 0, 8'h00);
        for (i = 0; i < 4; i++) begin
            if (i == 2) begin
                @(negedge clk);
                `CHK("pix_ready", 1'b0, pix_ready)
                `CHK("disp_status", {b[2], b[0]}, disp_status)
                @(posedge clk);
                stall <= 1'b0;
            end
            b = 8'($random(seed));
            op(1, `ACPP_IO_ATTR_INDEX, 16'h0031, 0);
            op(1, `ACPP_IO_ATTR_INDEX, {8'h00, b}, 0);
            px((i == 3) ? 8'h00 : b, i == 3);
        end
        op(0, 0, 0, 0);
        repeat (20) @(posedge clk);
        `CHK("rd_q", 0, rd_q.size())
        `CHK("vid_q", 0, vid_q.size())
        complete_run();
    end
endmodule // testbench
bind acpp_top acpp_props u_props (.clk, .rst, .io_addr, .io_rd, .io_wr, .io_rdata, .io_rvalid,
    .palette_read_strobe_n, .palette_write_strobe_n, .pal_sel_mask, .pal_rdata, .vid_valid,
    .vid_ready, .vid_data);
`default_nettype wire
